// *** src/pms_pkg.sv ***
// Package: constants and types for the power mode sequencer
package pms_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int IDLE_TIMEOUT_US = 1000;
   localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * CLK_MHZ;
   localparam int LP_WAKE_US = 500;
   localparam int LP_WAKE_CYC = LP_WAKE_US * CLK_MHZ;
   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
   localparam logic RST_SYNC_RST = 1'b0;

   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PMS_ACTIVE = 2'b00,
      PMS_IDLE = 2'b01,
      PMS_SLEEP = 2'b10,
      PMS_DEEP_OFF = 2'b11
   } pms_mode_t;
   localparam pms_mode_t MODE_RST = PMS_ACTIVE;
endpackage

// *** src/pms_power_mode_sequencer.sv ***
// Power mode sequencer: mode stepping, deep-off supply control, RF gating
// Functional notes
// - Four modes: active, idle, sleep, deep-off; sleep only if enabled.
// - Step to next lower mode after programmed inactivity period.
// - Activity returns directly to active from any lower mode.
// - Deep-off switches off core supply output and amplifier supply.
// - I/O domain stays powered in deep-off; user event restores power.
// - Deep-off entry disables on-chip regulator under firmware enable.
// - Low-power connection runs on low-power clock, wakes after period.
// - RF on during packet transmit or receive, or on register request, in any mode but deep-off.
// - Features invoked by register controls or baseband packet handling.
// - Low external reset holds the block in reset.
module pms_power_mode_sequencer
   import pms_pkg::*;
#(
   parameter int IDLE_TIMEOUT = pms_pkg::IDLE_TIMEOUT_CYC,
   parameter int LP_WAKE = pms_pkg::LP_WAKE_CYC
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic EXT_RESET_N,
   input wire logic USER_EVENT,
   input wire logic SLEEP_ENABLE,
   input wire logic [31:0] INACT_PERIOD,
   input wire logic REG_OFF_ENABLE,
   input wire logic LP_CONN_REQ,
   input wire logic REG_RF_REQ,
   input wire logic BB_TX_ACTIVE,
   input wire logic BB_RX_ACTIVE,
   input wire logic REG_DEEP_OFF_REQ,
   input wire logic BB_DEEP_OFF_REQ,
   output logic [1:0] POWER_MODE,
   output logic CORE_SUPPLY_EN,
   output logic AMP_SUPPLY_EN,
   output logic IO_SUPPLY_EN,
   output logic REGULATOR_EN,
   output logic LP_OSC_SEL,
   output logic LP_WAKE_PULSE,
   output logic RF_EN,
   output logic IN_RESET
);
   import pms_pkg::*;

   // ------------------------------------------------------------
   // Reset and input synchronisers
   // ------------------------------------------------------------
   // Pin inputs use three stages; only stages two and three are compared
   logic [2:0] xr_reg, xr_next;
   logic [2:0] ev_reg, ev_next;
   logic rst_ok_reg, rst_ok_next;
   logic act_reg, act_next;
   logic live;

   always_comb
   begin
      xr_next = {xr_reg[1:0], EXT_RESET_N};
      ev_next = {ev_reg[1:0], USER_EVENT};
      rst_ok_next = rst_ok_reg;
      act_next = act_reg;
      if (xr_reg[2] == xr_reg[1])
      begin
         rst_ok_next = xr_reg[2];
      end
      if (ev_reg[2] == ev_reg[1])
      begin
         act_next = ev_reg[2];
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         xr_reg <= 3'h0;
         ev_reg <= 3'h0;
         rst_ok_reg <= RST_SYNC_RST;
         act_reg <= 1'b0;
      end
      else
      begin
         xr_reg <= xr_next;
         ev_reg <= ev_next;
         rst_ok_reg <= rst_ok_next;
         act_reg <= act_next;
      end
   end

   // Held in reset until the synchronised external reset is high
   assign live = rst_ok_reg;

   // ------------------------------------------------------------
   // Mode sequencing
   // ------------------------------------------------------------
   pms_mode_t mode_reg, mode_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [CNT_W-1:0] lp_reg, lp_next;
   logic wake_reg, wake_next;
   logic deep_req;

   function automatic pms_mode_t lower_mode(pms_mode_t m, logic slp_en);
      pms_mode_t r;
      r = m;
      case (m)
         PMS_ACTIVE: r = PMS_IDLE;
         PMS_IDLE: r = slp_en ? PMS_SLEEP : PMS_DEEP_OFF;
         PMS_SLEEP: r = PMS_DEEP_OFF;
         PMS_DEEP_OFF: r = PMS_DEEP_OFF;
         default: r = PMS_ACTIVE;
      endcase
      return r;
   endfunction

   assign deep_req = REG_DEEP_OFF_REQ | BB_DEEP_OFF_REQ;

   always_comb
   begin
      mode_next = mode_reg;
      cnt_next = cnt_reg;
      lp_next = lp_reg;
      wake_next = 1'b0;
      if (!live)
      begin
         mode_next = MODE_RST;
         cnt_next = CNT_RST;
         lp_next = CNT_RST;
      end
      else if (act_reg)
      begin
         mode_next = PMS_ACTIVE;
         cnt_next = CNT_RST;
      end
      else if (deep_req)
      begin
         mode_next = PMS_DEEP_OFF;
         cnt_next = CNT_RST;
      end
      else if (mode_reg != PMS_DEEP_OFF)
      begin
         // A zero period falls back to the default timeout
         if (cnt_reg + 32'h1 >= ((INACT_PERIOD == 32'h0) ?
             32'(IDLE_TIMEOUT) : INACT_PERIOD))
         begin
            mode_next = lower_mode(mode_reg, SLEEP_ENABLE);
            cnt_next = CNT_RST;
         end
         else
         begin
            cnt_next = cnt_reg + 32'h1;
         end
      end
      // Low-power connection interval runs independently of mode stepping
      if (live && LP_CONN_REQ && !act_reg)
      begin
         if (lp_reg + 32'h1 >= 32'(LP_WAKE))
         begin
            lp_next = CNT_RST;
            wake_next = 1'b1;
         end
         else
         begin
            lp_next = lp_reg + 32'h1;
         end
      end
      else
      begin
         lp_next = CNT_RST;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         mode_reg <= MODE_RST;
         cnt_reg <= CNT_RST;
         lp_reg <= CNT_RST;
         wake_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         cnt_reg <= cnt_next;
         lp_reg <= lp_next;
         wake_reg <= wake_next;
      end
   end

   // ------------------------------------------------------------
   // Supply and RF controls
   // ------------------------------------------------------------
   logic core_reg, core_next;
   logic amp_reg, amp_next;
   logic regu_reg, regu_next;
   logic lpo_reg, lpo_next;
   logic rf_reg, rf_next;

   always_comb
   begin
      core_next = (mode_next != PMS_DEEP_OFF);
      amp_next = (mode_next != PMS_DEEP_OFF);
      regu_next = !(mode_next == PMS_DEEP_OFF && REG_OFF_ENABLE);
      lpo_next = live && LP_CONN_REQ && !act_reg;
      // RF follows the packet engine; register request also allowed
      rf_next = live && (mode_next != PMS_DEEP_OFF) &&
                (BB_TX_ACTIVE | BB_RX_ACTIVE | REG_RF_REQ);
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         core_reg <= 1'b1;
         amp_reg <= 1'b1;
         regu_reg <= 1'b1;
         lpo_reg <= 1'b0;
         rf_reg <= 1'b0;
      end
      else
      begin
         core_reg <= core_next;
         amp_reg <= amp_next;
         regu_reg <= regu_next;
         lpo_reg <= lpo_next;
         rf_reg <= rf_next;
      end
   end

   assign POWER_MODE = mode_reg;
   assign CORE_SUPPLY_EN = core_reg;
   assign AMP_SUPPLY_EN = amp_reg;
   // The I/O domain is never switched; it hosts the wake logic
   assign IO_SUPPLY_EN = 1'b1;
   assign REGULATOR_EN = regu_reg;
   assign LP_OSC_SEL = lpo_reg;
   assign LP_WAKE_PULSE = wake_reg;
   assign RF_EN = rf_reg;
   assign IN_RESET = !rst_ok_reg;
endmodule

// *** tb/pms_chk.sv ***
// Checker: port assertions for the power mode sequencer
module pms_chk
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic EXT_RESET_N,
   input wire logic USER_EVENT,
   input wire logic REG_OFF_ENABLE,
   input wire logic REG_RF_REQ,
   input wire logic BB_TX_ACTIVE,
   input wire logic BB_RX_ACTIVE,
   input wire logic [1:0] POWER_MODE,
   input wire logic CORE_SUPPLY_EN,
   input wire logic AMP_SUPPLY_EN,
   input wire logic REGULATOR_EN,
   input wire logic LP_WAKE_PULSE,
   input wire logic RF_EN,
   input wire logic IN_RESET
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   a_deep_supply: assert property (
      POWER_MODE == 2'h3 |-> !CORE_SUPPLY_EN && !AMP_SUPPLY_EN)
      else $error("on");
   a_reg_off: assert property (
      POWER_MODE == 2'h3 && REG_OFF_ENABLE && $stable(REG_OFF_ENABLE)
      |-> !REGULATOR_EN) else $error("regulator");
   a_rf_quiet: assert property (
      (!BB_TX_ACTIVE && !BB_RX_ACTIVE && !REG_RF_REQ)[*2] |-> !RF_EN)
      else $error("rf");
   a_sleep_entry: assert property (
      POWER_MODE == 2'h2 |-> $past(POWER_MODE) inside {2'h1, 2'h2})
      else $error("sleep");
   a_wake_active: assert property (
      (USER_EVENT && !IN_RESET)[*8] |-> POWER_MODE == 2'h0)
      else $error("wake");
   a_ext_hold: assert property (
      (!EXT_RESET_N)[*6] |-> IN_RESET && POWER_MODE == 2'h0)
      else $error("hold");
   a_start_active: assert property (
      $fell(IN_RESET) |-> POWER_MODE == 2'h0) else $error("start");
   a_lp_pulse: assert property (
      LP_WAKE_PULSE |=> !LP_WAKE_PULSE) else $error("pulse");
endmodule
bind pms_power_mode_sequencer pms_chk u_chk (.*);

// *** tb/pms_reset_host.sv ***
// Partner: host pin that holds the external reset low while supply settles
module pms_reset_host
#(
   parameter int HOLD = 50
)
(
   input wire logic clk,
   input wire logic req,
   output logic ext_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // HOLD cycles stand in for the long settle time to keep runs short
   // Counting on the rising edge keeps clear of the falling-edge request
   always @(posedge clk)
      cnt <= req ? 0 : (cnt < HOLD ? cnt + 1 : cnt);
   assign ext_n = !req && cnt >= HOLD;
endmodule

// *** tb/pms_power_mode_sequencer_bench.sv ***
// Bench: directed scenarios for the power mode sequencer
module pms_power_mode_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // Signals carry the port names so the instance connects by name
   logic MCLK = 0, RST_N = 0, USER_EVENT = 0, SLEEP_ENABLE = 0;
   logic REG_OFF_ENABLE = 1, LP_CONN_REQ = 0, REG_RF_REQ = 0;
   logic BB_TX_ACTIVE = 0, BB_RX_ACTIVE = 0;
   logic REG_DEEP_OFF_REQ = 0, BB_DEEP_OFF_REQ = 0;
   logic [31:0] INACT_PERIOD = 32'h14;
   wire logic EXT_RESET_N;
   logic [1:0] POWER_MODE;
   logic CORE_SUPPLY_EN, AMP_SUPPLY_EN, IO_SUPPLY_EN, REGULATOR_EN;
   logic LP_OSC_SEL, LP_WAKE_PULSE, RF_EN, IN_RESET;
   logic req = 1, saw = 0;
   int err_total = 0, compares = 0, cyc = 0;
   // Default period differs from the programmed one so both paths show
   localparam int IDLE_CYC = 24;
   pms_reset_host #(.HOLD(50)) host
   (
      .clk(MCLK),
      .req(req),
      .ext_n(EXT_RESET_N)
   );
   pms_power_mode_sequencer #(.IDLE_TIMEOUT(IDLE_CYC), .LP_WAKE(10)) uut (.*);
   always #5 MCLK = ~MCLK;
   always @(posedge MCLK)
   begin
      cyc++;
      if (POWER_MODE === 2'h2)
         saw = 1;
      if (cyc == 4000)
      begin
         err_total++;
         finish_test;
      end
   end
   task chk(input logic [1:0] s, input logic [1:0] e);
      compares++;
      if (s !== e)
      begin
         err_total++;
         $display("ERROR %0t got %b want %b", $time, s, e);
      end
   endtask
   task cy(input int n);
      repeat (n) @(negedge MCLK);
   endtask
   task wm(input logic [1:0] m, input int n);
      for (int i = 0; i < n && POWER_MODE !== m; i++)
         cy(1);
      chk(POWER_MODE, m);
   endtask
   task rwait;
      for (int i = 0; i < 90 && IN_RESET !== 1'b0; i++)
         cy(1);
      chk({IN_RESET, 1'b0}, 2'h0);
      chk(POWER_MODE, 2'h0);
   endtask
   task step(input logic s, input logic [31:0] p, input int per);
      SLEEP_ENABLE = s;
      INACT_PERIOD = p;
      USER_EVENT = 1;
      cy(6);
      chk(POWER_MODE, 2'h0);
      chk({CORE_SUPPLY_EN, AMP_SUPPLY_EN}, 2'h3);
      USER_EVENT = 0;
      cy(14);
      USER_EVENT = 1;
      cy(8);
      USER_EVENT = 0;
      cy(16);
      chk(POWER_MODE, 2'h0);
      saw = 0;
      // Idle falls due exactly per cycles after the synchronised release
      cy(per - 13);
      chk(POWER_MODE, 2'h0);
      cy(1);
      chk(POWER_MODE, 2'h1);
      if (s)
         wm(2'h2, 30);
      wm(2'h3, 30);
      chk({saw, IO_SUPPLY_EN}, {s, 1'b1});
      chk({CORE_SUPPLY_EN, AMP_SUPPLY_EN}, 2'h0);
      chk({REGULATOR_EN, RF_EN}, 2'h0);
   endtask
   task deep_req;
      for (int j = 0; j < 2; j++)
      begin
         REG_OFF_ENABLE = (j == 1);
         USER_EVENT = 1;
         wm(2'h0, 10);
         USER_EVENT = 0;
         {REG_DEEP_OFF_REQ, BB_DEEP_OFF_REQ} = j ? 2'h1 : 2'h2;
         wm(2'h3, 10);
         chk({REGULATOR_EN, CORE_SUPPLY_EN}, j ? 2'h0 : 2'h2);
         {REG_DEEP_OFF_REQ, BB_DEEP_OFF_REQ} = 2'h0;
      end
   endtask
   task rf_gate;
      USER_EVENT = 1;
      wm(2'h0, 10);
      for (int k = 0; k < 3; k++)
      begin
         {REG_RF_REQ, BB_RX_ACTIVE, BB_TX_ACTIVE} = 3'h1 << k;
         cy(3);
         chk({1'b0, RF_EN}, 2'h1);
         {REG_RF_REQ, BB_RX_ACTIVE, BB_TX_ACTIVE} = 3'h0;
         cy(3);
         chk({1'b0, RF_EN}, 2'h0);
      end
      USER_EVENT = 0;
   endtask
   task lp_run;
      int n;
      n = 0;
      LP_CONN_REQ = 1;
      cy(8);
      chk({1'b0, LP_OSC_SEL}, 2'h1);
      for (int i = 0; i < 40; i++)
      begin
         cy(1);
         n += LP_WAKE_PULSE;
      end
      chk({1'b0, n == 4}, 2'h1);
      LP_CONN_REQ = 0;
   endtask
   task finish_test;
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      cy(20);
      RST_N = 1;
      req = 0;
      rwait;
      step(1'b1, 32'h14, 20);
      step(1'b0, 32'h0, IDLE_CYC);
      deep_req;
      rf_gate;
      lp_run;
      req = 1;
      cy(8);
      chk({IN_RESET, POWER_MODE[0]}, 2'h2);
      chk(POWER_MODE, 2'h0);
      req = 0;
      rwait;
      finish_test;
   end
endmodule
